// ===== core/wbm_core.sv
// Write buffer command interpreter with an AXI4-Lite register slave.
// Assumes one clock, activation events as one-cycle pulses, and a single initiator driver.
//
// How it works
// - Data mode with nonzero buffer ID fails with illegal request, invalid field.
// - Data mode offset beyond the buffer fails with invalid field.
// - Data mode length plus offset below capacity, sector aligned, else fails.
// - Data mode zero length moves nothing and returns good status.
// - Microcode mode accepts main ID 00h or vendor ID; others fail.
// - Microcode mode nonzero buffer offset fails with invalid field.
// - Microcode zero length changes nothing; otherwise length equals image size.
// - Downloaded microcode runs at once until the next power cycle.
// - Microcode download posts unit attention to every other initiator.
// - Save mode stores image and activates after self-started power-on reset.
// - Segment length not a multiple of 4K fails with invalid field.
// - After a check, buffer ID 00h restarts the file; else ID ignored.
// - After the last segment the device behaves as save mode.
// - Echo mode writes word aligned data into the shared buffer.
// - Echo contents stay valid until any later command arrives.
// - Select activation mode saves deferred code; mode 0Fh activates it.
// - Bit 7 set lets power-on activate deferred code.
// - Bit 6 set lets hard reset activate deferred code.
// - Bit 5 set lets a vendor event activate deferred code.
// - Any unsupported mode fails with illegal request, invalid field.
`timescale 1ns/100ps
`include "wbm_cfg.svh"

module wbm_core
  import wbm_pkg::*;
#(
  parameter int BUF_WORDS = `WBM_BUF_WORDS,
  parameter int SECTOR_B = `WBM_SECTOR_B,
  parameter int SEG_UNIT_B = `WBM_SEG_UNIT_B,
  parameter int UCODE_B = `WBM_UCODE_B,
  parameter int INITS = `WBM_INITS,
  parameter logic [7:0] VU_BID = `WBM_VU_BID
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_evt,
  input wire logic hard_reset_evt,
  input wire logic vendor_evt,
  output logic self_reset_req,
  output logic code_live,
  output logic deferred_pending
);

  localparam logic [24:0] CAP_B = 25'(BUF_WORDS * 4);
  localparam logic [23:0] UCODE_LEN = 24'(UCODE_B);
  localparam int PW = $clog2(BUF_WORDS);

  // Applies write strobes to a stored word.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // True when a byte count is a whole multiple of a power of two unit.
  function automatic logic is_mult(input logic [23:0] v, input int unit);
    return (v & 24'(unit - 1)) == 24'h000000;
  endfunction

  // Bus handshake state.
  logic aw_held_reg, w_held_reg, bvalid_reg, awready_reg, wready_reg;
  logic arready_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Command and microcode state.
  logic [31:0] cdb0_reg;
  logic [23:0] off_reg, len_reg, seg_cnt_reg;
  logic [21:0] words_left_reg;
  logic [PW-1:0] wptr_reg, echo_idx_reg;
  wbm_state_t state_reg;
  wbm_mode_t act_mode_reg;
  logic check_reg, done_reg, echo_valid_reg, seg_after_chk_reg;
  logic [3:0] sense_key_reg;
  logic [7:0] asc_reg;
  logic live_reg, save_pend_reg, saved_act_reg, defer_reg, def_act_reg, sreset_reg;
  logic [2:0] act_bits_reg;
  logic [INITS-1:0] ua_reg;
  logic [31:0] buf_mem [BUF_WORDS];

  // Write channel decode.
  wire aw_fire = s_axi_awvalid & awready_reg;
  wire w_fire = s_axi_wvalid & wready_reg;
  wire aw_have = aw_held_reg | aw_fire;
  wire w_have = w_held_reg | w_fire;
  wire wr_do = aw_have & w_have;
  wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire aw_held_next = aw_have & ~wr_do;
  wire w_held_next = w_have & ~wr_do;
  wire bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);
  wire ar_fire = s_axi_arvalid & arready_reg;
  wire rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);

  // Register strobes.
  wire wr_cdb0 = wr_do & (wr_addr == `WBM_OFF_CDB0);
  wire wr_off = wr_do & (wr_addr == `WBM_OFF_OFFSET);
  wire wr_len = wr_do & (wr_addr == `WBM_OFF_LENGTH);
  wire wr_cmd = wr_do & (wr_addr == `WBM_OFF_CMD);
  wire wr_dat = wr_do & (wr_addr == `WBM_OFF_DATA);
  wire wr_ua = wr_do & (wr_addr == `WBM_OFF_UATTN);
  wire wr_eidx = wr_do & (wr_addr == `WBM_OFF_ECHO_IDX);
  wire wr_ok = wr_cdb0 | wr_off | wr_len | wr_cmd | wr_dat | wr_ua | wr_eidx;

  // Descriptor fields.
  wire [4:0] mode_f = cdb0_reg[`WBM_CDB0_MODE_LSB +: 5];
  wire [7:0] ms_f = cdb0_reg[`WBM_CDB0_MS_LSB +: 8];
  wire [7:0] bid_f = cdb0_reg[`WBM_CDB0_BID_LSB +: 8];
  wire [7:0] init_f = cdb0_reg[`WBM_CDB0_INIT_LSB +: 8];
  wire [24:0] end_b = {1'b0, len_reg} + {1'b0, off_reg};
  wire len_zero = (len_reg == 24'h000000);
  wire len_word = is_mult(len_reg, 4);

  // A command is taken only while no data phase is open.
  wire issue = wr_cmd & wr_data[0] & (state_reg == WBM_ST_IDLE);

  // Per mode field checks; each yields a failure flag.
  wire data_bad = (bid_f != 8'h00)
                | ({1'b0, off_reg} > CAP_B)
                | (end_b >= CAP_B) | ~is_mult(len_reg, SECTOR_B);
  wire uc_bad = ((bid_f != `WBM_MAIN_BID) & (bid_f != VU_BID))
              | (off_reg != 24'h000000)
              | (~len_zero & (len_reg != UCODE_LEN));
  wire seg_bad = len_zero | ~is_mult(len_reg, SEG_UNIT_B);
  wire echo_bad = ~len_word | ({1'b0, len_reg} > CAP_B);

  // Mode dispatch: failure, and whether a data phase follows.
  logic cmd_bad, cmd_xfer;
  always_comb begin
    cmd_bad = 1'b0;
    cmd_xfer = 1'b0;
    unique case (mode_f)
      WBM_MODE_DATA: begin
        cmd_bad = data_bad;
        cmd_xfer = ~len_zero;
      end
      WBM_MODE_UC: begin
        cmd_bad = uc_bad;
        cmd_xfer = ~len_zero;
      end
      WBM_MODE_SAVE: begin
        cmd_bad = ~len_word;
        cmd_xfer = ~len_zero;
      end
      WBM_MODE_SEG: begin
        cmd_bad = seg_bad;
        cmd_xfer = 1'b1;
      end
      WBM_MODE_ECHO, WBM_MODE_EXP: begin
        cmd_bad = echo_bad;
        cmd_xfer = ~len_zero;
      end
      WBM_MODE_DEFSEL: begin
        cmd_bad = ~len_word;
        cmd_xfer = ~len_zero;
      end
      WBM_MODE_ACT: begin
        cmd_bad = 1'b0;
        cmd_xfer = 1'b0;
      end
      default: begin
        cmd_bad = 1'b1;
        cmd_xfer = 1'b0;
      end
    endcase
  end

  // Command outcomes and the end of a data phase.
  wire issue_bad = issue & cmd_bad;
  wire issue_go = issue & ~cmd_bad & cmd_xfer;
  wire issue_now = issue & ~cmd_bad & ~cmd_xfer;
  wire last_word = (state_reg == WBM_ST_DATA) & wr_dat & (words_left_reg == 22'h000001);
  wire [4:0] fin_mode = issue_now ? mode_f : act_mode_reg;
  wire fin = last_word | issue_now;
  wire store_word = (state_reg == WBM_ST_DATA) & wr_dat &
                    ((act_mode_reg == WBM_MODE_DATA) | (act_mode_reg == WBM_MODE_ECHO) |
                     (act_mode_reg == WBM_MODE_EXP));

  // Segment bookkeeping.
  wire seg_restart = issue & (mode_f == WBM_MODE_SEG) & seg_after_chk_reg &
                     (bid_f == 8'h00);
  wire [23:0] seg_sum = seg_cnt_reg + len_reg;
  wire seg_last = last_word & (act_mode_reg == WBM_MODE_SEG) & (seg_sum >= UCODE_LEN);
  wire uc_done = fin & (fin_mode == WBM_MODE_UC) & ~len_zero;
  wire save_done = (fin & (fin_mode == WBM_MODE_SAVE) & ~len_zero) | seg_last;
  wire defer_done = fin & (fin_mode == WBM_MODE_DEFSEL) & ~len_zero;
  wire act_cmd = issue_now & (mode_f == WBM_MODE_ACT);

  // Deferred code activation sources.
  wire activate = defer_reg & (act_cmd
                | (power_on_evt & act_bits_reg[2])
                | (hard_reset_evt & act_bits_reg[1])
                | (vendor_evt & act_bits_reg[0]));

  // Unit attention mask for every initiator but the issuer.
  logic [INITS-1:0] ua_others;
  always_comb begin
    ua_others = '1;
    for (int i = 0; i < INITS; i++) begin
      if (init_f == 8'(i)) begin
        ua_others[i] = 1'b0;
      end
    end
  end

  // Read data selection.
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `WBM_OFF_CDB0: rd_word = cdb0_reg;
      `WBM_OFF_OFFSET: rd_word = {8'h00, off_reg};
      `WBM_OFF_LENGTH: rd_word = {8'h00, len_reg};
      `WBM_OFF_CMD: rd_word = 32'h00000000;
      `WBM_OFF_DATA: rd_word = {10'h000, words_left_reg};
      `WBM_OFF_STATUS: rd_word = {8'h00, asc_reg, 4'h0, sense_key_reg, 3'h0,
                                  seg_after_chk_reg, echo_valid_reg, done_reg, check_reg,
                                  state_reg == WBM_ST_DATA};
      `WBM_OFF_UCODE: rd_word = {23'h000000, act_bits_reg, sreset_reg, def_act_reg,
                                 defer_reg, saved_act_reg, save_pend_reg, live_reg};
      `WBM_OFF_UATTN: rd_word = 32'(ua_reg);
      `WBM_OFF_SEGCNT: rd_word = {8'h00, seg_cnt_reg};
      `WBM_OFF_ECHO_IDX: rd_word = 32'(echo_idx_reg);
      `WBM_OFF_ECHO_RD: rd_word = buf_mem[echo_idx_reg];
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // AXI handshake registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      bresp_reg <= `WBM_RESP_OKAY;
      rresp_reg <= `WBM_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= ~aw_held_next & ~bvalid_next;
      wready_reg <= ~w_held_next & ~bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (aw_fire) aw_addr_reg <= s_axi_awaddr;
      if (w_fire) w_data_reg <= s_axi_wdata;
      if (w_fire) w_strb_reg <= s_axi_wstrb;
      if (wr_do) bresp_reg <= wr_ok ? `WBM_RESP_OKAY : `WBM_RESP_SLVERR;
      if (ar_fire) rdata_reg <= rd_word;
      if (ar_fire) rresp_reg <= rd_hit ? `WBM_RESP_OKAY : `WBM_RESP_SLVERR;
    end
  end

  // Strobe merged views of the offset and length words; only the low 24 bits are kept.
  wire [31:0] off_merged = strb_merge({8'h00, off_reg}, wr_data, wr_strb);
  wire [31:0] len_merged = strb_merge({8'h00, len_reg}, wr_data, wr_strb);

  // Descriptor registers written by software.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cdb0_reg <= 32'h00000000;
      off_reg <= 24'h000000;
      len_reg <= 24'h000000;
      echo_idx_reg <= '0;
    end else begin
      if (wr_cdb0) cdb0_reg <= strb_merge(cdb0_reg, wr_data, wr_strb);
      if (wr_off) off_reg <= off_merged[23:0];
      if (wr_len) len_reg <= len_merged[23:0];
      if (wr_eidx) echo_idx_reg <= wr_data[PW-1:0];
    end
  end

  // Command sequencer, status and sense.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= WBM_ST_IDLE;
      act_mode_reg <= WBM_MODE_DATA;
      words_left_reg <= 22'h000000;
      wptr_reg <= '0;
      check_reg <= 1'b0;
      done_reg <= 1'b0;
      sense_key_reg <= `WBM_SK_NONE;
      asc_reg <= `WBM_ASC_NONE;
    end else begin
      if (issue) begin
        check_reg <= issue_bad;
        done_reg <= issue_bad | issue_now;
        sense_key_reg <= issue_bad ? `WBM_SK_ILLEGAL : `WBM_SK_NONE;
        asc_reg <= issue_bad ? `WBM_ASC_INV_FIELD : `WBM_ASC_NONE;
        act_mode_reg <= wbm_mode_t'(mode_f);
        words_left_reg <= len_reg[23:2];
        wptr_reg <= PW'(off_reg[23:2]);
      end
      if (issue_go) state_reg <= WBM_ST_DATA;
      if ((state_reg == WBM_ST_DATA) & wr_dat) begin
        words_left_reg <= words_left_reg - 22'h000001;
        wptr_reg <= wptr_reg + PW'(1);
      end
      if (last_word) begin
        state_reg <= WBM_ST_IDLE;
        done_reg <= 1'b1;
      end
    end
  end

  // Data and echo buffer storage, word aligned.
  always_ff @(posedge clk) begin
    if (store_word) buf_mem[wptr_reg] <= wr_data;
  end

  // Echo validity: kept until the next command register write with bit 0 set, even one not taken.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      echo_valid_reg <= 1'b0;
    end else if (wr_cmd & wr_data[0]) begin
      echo_valid_reg <= 1'b0;
    end else if (last_word & ((act_mode_reg == WBM_MODE_ECHO) | (act_mode_reg == WBM_MODE_EXP))) begin
      echo_valid_reg <= 1'b1;
    end
  end

  // Segment counter and restart marker.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_cnt_reg <= 24'h000000;
      seg_after_chk_reg <= 1'b0;
    end else begin
      if (issue & (mode_f == WBM_MODE_SEG)) seg_after_chk_reg <= issue_bad;
      if (seg_restart) seg_cnt_reg <= 24'h000000;
      if (last_word & (act_mode_reg == WBM_MODE_SEG)) begin
        seg_cnt_reg <= seg_last ? 24'h000000 : seg_sum;
      end
    end
  end

  // Microcode state: live, saved, deferred and activation choices.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      live_reg <= 1'b0;
      save_pend_reg <= 1'b0;
      saved_act_reg <= 1'b0;
      sreset_reg <= 1'b0;
      defer_reg <= 1'b0;
      def_act_reg <= 1'b0;
      act_bits_reg <= 3'h0;
    end else begin
      if (power_on_evt) live_reg <= 1'b0;
      if (uc_done) live_reg <= 1'b1;
      if (power_on_evt & save_pend_reg) begin
        save_pend_reg <= 1'b0;
        saved_act_reg <= 1'b1;
        sreset_reg <= 1'b0;
      end
      if (save_done) begin
        save_pend_reg <= 1'b1;
        sreset_reg <= 1'b1;
      end
      if (activate) begin
        defer_reg <= 1'b0;
        def_act_reg <= 1'b1;
      end
      if (defer_done) begin
        defer_reg <= 1'b1;
        act_bits_reg <= {ms_f[`WBM_MS_PO_BIT], ms_f[`WBM_MS_HR_BIT], ms_f[`WBM_MS_VE_BIT]};
      end
    end
  end

  // Unit attention flags: posting wins over a software clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ua_reg <= '0;
    end else begin
      ua_reg <= (ua_reg & ~(wr_ua ? wr_data[INITS-1:0] : '0)) | (uc_done ? ua_others : '0);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign self_reset_req = sreset_reg;
  assign code_live = live_reg;
  assign deferred_pending = defer_reg;

  // Checks on command outcomes.
  data_bid_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_DATA) & (bid_f != 8'h00) |=>
      check_reg & (sense_key_reg == `WBM_SK_ILLEGAL) & (state_reg == WBM_ST_IDLE))
    else $error("Data mode with nonzero buffer ID was not refused.");
  data_len_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_DATA) & (end_b >= CAP_B) |=> check_reg & (asc_reg == `WBM_ASC_INV_FIELD))
    else $error("Data mode length beyond capacity was not refused.");
  data_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_DATA) & len_zero & (bid_f == 8'h00) & (off_reg == 24'h000000) |=>
      done_reg & ~check_reg & (state_reg == WBM_ST_IDLE))
    else $error("Zero length data command did not complete at once.");
  uc_off_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_UC) & (off_reg != 24'h000000) |=> check_reg ##1 ~live_reg | $past(live_reg))
    else $error("Microcode mode with offset was not refused.");
  uc_ua_a: assert property (@(posedge clk) disable iff (!nrst)
    uc_done |=> ((ua_reg & ua_others) == ua_others) & live_reg)
    else $error("Microcode change did not post attention to other initiators.");
  seg_len_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_SEG) & ~is_mult(len_reg, SEG_UNIT_B) |=> check_reg ##1 seg_after_chk_reg)
    else $error("Segment length not a multiple of the unit was not refused.");
  bad_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    issue & (mode_f == WBM_MODE_DEFER) |=> check_reg & (sense_key_reg == `WBM_SK_ILLEGAL))
    else $error("Unsupported mode was not refused.");
  power_on_activate_a: assert property (@(posedge clk) disable iff (!nrst)
    defer_reg & power_on_evt & ~act_bits_reg[2] & ~act_cmd & ~hard_reset_evt & ~vendor_evt |=> defer_reg)
    else $error("Power on activated deferred code while not enabled.");
  save_act_a: assert property (@(posedge clk) disable iff (!nrst)
    save_done |=> save_pend_reg & self_reset_req & ~saved_act_reg | $past(saved_act_reg))
    else $error("Saved image did not wait for a self reset.");

endmodule

// ===== pkg/wbm_cfg.svh
// Register map, field positions, sense codes and sizes for the write buffer block.
// Assumes it is included by bare name wherever these values are needed.
`ifndef WBM_CFG_SVH
`define WBM_CFG_SVH

// Byte addresses of the AXI4-Lite registers.
`define WBM_OFF_CDB0     8'h00
`define WBM_OFF_OFFSET   8'h04
`define WBM_OFF_LENGTH   8'h08
`define WBM_OFF_CMD      8'h0C
`define WBM_OFF_DATA     8'h10
`define WBM_OFF_STATUS   8'h14
`define WBM_OFF_UCODE    8'h18
`define WBM_OFF_UATTN    8'h1C
`define WBM_OFF_SEGCNT   8'h20
`define WBM_OFF_ECHO_IDX 8'h24
`define WBM_OFF_ECHO_RD  8'h28

// Field positions inside the command descriptor word.
`define WBM_CDB0_MODE_LSB 0
`define WBM_CDB0_MS_LSB   8
`define WBM_CDB0_BID_LSB  16
`define WBM_CDB0_INIT_LSB 24

// Activation bits inside the mode specific byte.
`define WBM_MS_PO_BIT 7
`define WBM_MS_HR_BIT 6
`define WBM_MS_VE_BIT 5

// Sense values reported on a failed check.
`define WBM_SK_NONE       4'h0
`define WBM_SK_ILLEGAL    4'h5
`define WBM_ASC_NONE      8'h00
`define WBM_ASC_INV_FIELD 8'h24

// Sizes and codes used in length and buffer checks.
`define WBM_BUF_WORDS   256
`define WBM_SECTOR_B    512
`define WBM_SEG_UNIT_B  4096
`define WBM_UCODE_B     8192
`define WBM_INITS       4
`define WBM_MAIN_BID    8'h00
`define WBM_VU_BID      8'h01

// AXI response codes.
`define WBM_RESP_OKAY   2'h0
`define WBM_RESP_SLVERR 2'h2

`endif

// ===== pkg/wbm_pkg.sv
// Types shared by the write buffer block: command modes and sequencer states.
// Assumes the constants header is compiled alongside.
package wbm_pkg;

  // Write buffer mode codes as carried in the descriptor.
  typedef enum logic [4:0] {
    WBM_MODE_HDR    = 5'b00000,
    WBM_MODE_DATA   = 5'b00010,
    WBM_MODE_UC     = 5'b00100,
    WBM_MODE_SAVE   = 5'b00101,
    WBM_MODE_SEG    = 5'b00111,
    WBM_MODE_ECHO   = 5'b01010,
    WBM_MODE_DEFSEL = 5'b01101,
    WBM_MODE_DEFER  = 5'b01110,
    WBM_MODE_ACT    = 5'b01111,
    WBM_MODE_EXP    = 5'b11010
  } wbm_mode_t;

  // Sequencer: idle, or waiting for the data out words.
  typedef enum logic [0:0] {
    WBM_ST_IDLE = 1'b0,
    WBM_ST_DATA = 1'b1
  } wbm_state_t;

endpackage

// ===== verif/scsi_write_buffer_modes_test.sv
// Self-checking bench for the write buffer command interpreter.
// Assumes the initiator model drives the register bus and events are pulses.
`timescale 1ns/100ps
`include "wbm_cfg.svh"
module scsi_write_buffer_modes_test;
  import wbm_pkg::*;
  localparam logic [31:0] CHK = 32'h0024_0506;
  localparam logic [31:0] DN = 32'h0000_0004;
  logic clk, nrst, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, sr, live, defp;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, d1;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [2:0] ev;
  logic [65:0] q[$];
  logic [1:0] bexp = 2'h0;
  logic [4:0] bad_modes [4] = '{5'h00, 5'h01, 5'h0E, 5'h1F};
  int errors = 0;
  int checks = 0;

  wbm_core dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .power_on_evt(ev[2]),
    .hard_reset_evt(ev[1]), .vendor_evt(ev[0]), .self_reset_req(sr), .code_live(live),
    .deferred_pending(defp));
  wbm_host host (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd),
    .wstrb(ws), .wvalid(wv), .wready(wr_), .bvalid(bv), .bready(br), .araddr(ara),
    .arvalid(arv), .arready(arr), .rvalid(rv), .rready(rr));

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Notes the expected masked word and response, then reads.
  task automatic rs(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1, logic [1:0] r = 0);
    q.push_back({r, m, e & m});
    host.rd(a);
  endtask

  task automatic st(logic [31:0] e);
    rs(`WBM_OFF_STATUS, e, 32'h00FF_0F07);
  endtask

  task automatic cmd(logic [4:0] md, logic [7:0] ms, bid, logic [23:0] off, len,
      logic [7:0] ini = 0);
    host.wr(`WBM_OFF_CDB0, {ini, bid, ms, 3'h0, md});
    host.wr(`WBM_OFF_OFFSET, {8'h0, off});
    host.wr(`WBM_OFF_LENGTH, {8'h0, len});
    host.wr(`WBM_OFF_CMD, 32'h1);
  endtask

  task automatic words(int n);
    for (int i = 0; i < n; i++) host.wr(`WBM_OFF_DATA, $urandom);
  endtask

  task automatic pulse(int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Takes the oldest note whenever read data are accepted.
  always @(posedge clk) begin
    if (rv === 1'b1 && rr && q.size() != 0) begin
      cmp("rdata", q[0][31:0], rdata & q[0][63:32]);
      cmp("rresp", {30'h0, q[0][65:64]}, {30'h0, rresp});
      void'(q.pop_front());
    end
    if (bv === 1'b1 && br === 1'b1) begin
      cmp("bresp", {30'h0, bexp}, {30'h0, bresp});
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #1000000;
    errors++;
    report_and_stop;
  end

  initial begin
    nrst = 1'b0;
    ev = 3'h0;
    void'($urandom(75440));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    cmd(WBM_MODE_DATA, 0, 8'(1 + $urandom % 255), 0, 512); st(CHK);
    cmd(WBM_MODE_DATA, 0, 0, 1028, 512); st(CHK);
    cmd(WBM_MODE_DATA, 0, 0, 0, 1024); st(CHK);
    cmd(WBM_MODE_DATA, 0, 0, 0, 100); st(CHK);
    cmd(WBM_MODE_DATA, 0, 0, 0, 0); st(DN);
    cmd(WBM_MODE_DATA, 0, 0, 0, 512); st(32'h1);
    words(128); st(DN);
    cmd(WBM_MODE_UC, 0, 8'h02, 0, 8192); st(CHK);
    cmd(WBM_MODE_UC, 0, 0, 4, 8192); st(CHK);
    cmd(WBM_MODE_UC, 0, 0, 0, 0); st(DN);
    cmd(WBM_MODE_UC, 0, 0, 0, 8192, 8'h1); words(2048); st(DN);
    cmp("code_live", 1, {31'h0, live});
    rs(`WBM_OFF_UATTN, 32'hD, 32'hF);
    pulse(2); cmp("code_live", 0, {31'h0, live});
    cmd(WBM_MODE_SAVE, 0, 0, 0, 16); words(4); cmp("self_reset", 1, {31'h0, sr});
    pulse(2); cmp("self_reset", 0, {31'h0, sr});
    cmd(WBM_MODE_SEG, 0, 0, 0, 100); st(CHK);
    cmd(WBM_MODE_SEG, 0, 0, 0, 4096); words(1024); rs(`WBM_OFF_SEGCNT, 4096);
    cmd(WBM_MODE_SEG, 0, 8'h33, 8, 4096); words(1024); rs(`WBM_OFF_SEGCNT, 0);
    cmp("self_reset", 1, {31'h0, sr});
    pulse(2);
    d1 = $urandom;
    cmd(WBM_MODE_ECHO, 0, 0, 0, 8); words(1); host.wr(`WBM_OFF_DATA, d1);
    host.wr(`WBM_OFF_ECHO_IDX, 1); rs(`WBM_OFF_ECHO_RD, d1);
    rs(`WBM_OFF_STATUS, 8, 8);
    cmd(WBM_MODE_DATA, 0, 0, 0, 0); rs(`WBM_OFF_STATUS, 0, 8);
    rs(`WBM_OFF_ECHO_RD, d1);
    cmd(WBM_MODE_EXP, 0, 0, 4, 4); host.wr(`WBM_OFF_DATA, ~d1);
    rs(`WBM_OFF_ECHO_RD, ~d1);
    for (int k = 0; k < 3; k++) begin
      cmd(WBM_MODE_DEFSEL, 8'(32'h20 << k), 0, 0, 4); words(1);
      cmp("deferred", 1, {31'h0, defp});
      pulse((k + 1) % 3); cmp("deferred", 1, {31'h0, defp});
      pulse(k); cmp("deferred", 0, {31'h0, defp});
    end
    cmd(WBM_MODE_DEFSEL, 0, 0, 0, 4); words(1);
    cmd(WBM_MODE_ACT, 0, 0, 0, 0); cmp("deferred", 0, {31'h0, defp});
    foreach (bad_modes[i]) begin
      cmd(bad_modes[i], 0, 0, 0, 0); st(CHK);
    end
    rs(8'h30, 0, '1, 2'h2);
    bexp <= 2'h2;
    host.wr(8'h30, 32'h0);
    bexp <= 2'h0;
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule

// ===== verif/wbm_host.sv
// Initiator model that issues register cycles over AXI4-Lite.
// Assumes one clock and a slave that answers every request it takes.
`timescale 1ns/100ps
module wbm_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  // All requests start idle.
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  // Offers address and data together, drops each once taken, waits for the response.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  // Holds the read address until taken and rready until the data arrive.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule
